// ==== pvt_regs.vh ====
// Purpose: constants of the panel video timing host controller
// Assumes: core_clk at 125 MHz, byte offsets on the register port
// Notes:   cycle counts derive from the sequence times
`ifndef PVT_REGS_VH
`define PVT_REGS_VH

`define PVT_ADDR_CTRL      8'h00
`define PVT_ADDR_HBLANK    8'h04
`define PVT_ADDR_VBLANK    8'h08
`define PVT_ADDR_COLOR     8'h0c
`define PVT_ADDR_STATUS    8'h10
`define PVT_ADDR_FRAMES    8'h14

`define PVT_CTRL_RUN       0
`define PVT_CTRL_BL        1
`define PVT_CTRL_HDIR      2
`define PVT_CTRL_VDIR      3
`define PVT_CTRL_RAMP      4
`define PVT_CTRL_W         5
`define PVT_CTRL_RST       5'h0c

`define PVT_HACT           11'h500
`define PVT_VACT           11'h3c0
`define PVT_HBLANK_MIN     11'h006
`define PVT_HBLANK_TYP     11'h008
`define PVT_HBLANK_MAX     11'h00a
`define PVT_VBLANK_MIN     11'h03c
`define PVT_VBLANK_TYP     11'h040
`define PVT_VBLANK_MAX     11'h070
`define PVT_COLOR_RST      24'h000000

`define PVT_CLK_NS         8
`define PVT_T1_MIN_US      500
`define PVT_T2_US          1000
`define PVT_T3_US          1000
`define PVT_T1_CYC  ((`PVT_T1_MIN_US * 1000 + `PVT_CLK_NS - 1) / `PVT_CLK_NS)
`define PVT_T2_CYC  ((`PVT_T2_US * 1000) / `PVT_CLK_NS)
`define PVT_T3_CYC  ((`PVT_T3_US * 1000) / `PVT_CLK_NS)

`endif

// ==== pvt_sync.v ====
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to core_clk
// Notes:   first flop feeds only the second
`default_nettype none
module pvt_sync (
  input  wire core_clk,
  input  wire sys_rst,
  input  wire asyncIn,
  output wire syncOut
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule
`default_nettype wire

// ==== pvt_host_ctrl.v ====
// Purpose: host side video source and power sequencer for the panel
// Assumes: pixel clock reference arrives on pixelClkRef from a PLL
// Notes:   timing advances on each sampled rising edge of the reference
//
// Strobed register access and the register addresses were decided locally.
`include "pvt_regs.vh"
`default_nettype none
module pvt_host_ctrl #(
  parameter [31:0] T1_CYCLES = `PVT_T1_CYC,
  parameter [31:0] T2_CYCLES = `PVT_T2_CYC,
  parameter [31:0] T3_CYCLES = `PVT_T3_CYC
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [31:0] regRdData,
  input  wire        pixelClkRef,
  output reg         panelVccEn,
  output reg         backlightEn,
  output reg         panelResetN,
  output reg         panelStandbyN,
  output reg         horizScanDir,
  output reg         vertScanDir,
  output reg         pixelClk,
  output reg         pixelValid,
  output reg  [7:0]  pixRed,
  output reg  [7:0]  pixGreen,
  output reg  [7:0]  pixBlue,
  output reg         hsyncOut,
  output reg         vsyncOut
);
  localparam [5:0] S_OFF   = 6'h01;
  localparam [5:0] S_PWRUP = 6'h02;
  localparam [5:0] S_SIGON = 6'h04;
  localparam [5:0] S_RUN   = 6'h08;
  localparam [5:0] S_STOP1 = 6'h10;
  localparam [5:0] S_STOP2 = 6'h20;

  reg [`PVT_CTRL_W-1:0] ctrl_ff;
  reg [10:0]            hBlankReg_ff;
  reg [10:0]            vBlankReg_ff;
  reg [10:0]            hBlankAct_ff;
  reg [10:0]            vBlankAct_ff;
  reg [23:0]            color_ff;
  reg [15:0]            frameCnt_ff;
  reg [10:0]            hCnt_ff;
  reg [10:0]            vCnt_ff;
  reg [5:0]             state_ff;
  reg [5:0]             nxt_state;
  reg [31:0]            waitCnt_ff;
  reg [31:0]            nxt_waitCnt;
  reg                   pixPrev_ff;
  wire                  pixSync;
  wire                  pixEdge;
  wire                  sigOn;
  wire                  runReq;
  wire [10:0]           hTotal;
  wire [10:0]           vTotal;
  wire                  lineEnd;
  wire                  frameEnd;
  wire                  activeNow;
  wire [7:0]            rampLevel;

  function [10:0] clampRange;
    input [10:0] val;
    input [10:0] lo;
    input [10:0] hi;
    begin
      if (val < lo) begin
        clampRange = lo;
      end else if (val > hi) begin
        clampRange = hi;
      end else begin
        clampRange = val;
      end
    end
  endfunction

  pvt_sync u_pixSync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (pixelClkRef),
    .syncOut  (pixSync)
  );

  assign pixEdge   = pixSync & ~pixPrev_ff;
  assign runReq    = ctrl_ff[`PVT_CTRL_RUN];
  // signals run from release of reset until S_STOP1 ends, T2 after backlight has gone off
  assign sigOn     = (state_ff == S_SIGON) || (state_ff == S_RUN) ||
                     (state_ff == S_STOP1);
  assign hTotal    = `PVT_HACT + hBlankAct_ff;
  assign vTotal    = `PVT_VACT + vBlankAct_ff;
  assign lineEnd   = (hCnt_ff == hTotal - 11'h001);
  assign frameEnd  = lineEnd && (vCnt_ff == vTotal - 11'h001);
  assign activeNow = (hCnt_ff < `PVT_HACT) && (vCnt_ff < `PVT_VACT);
  assign rampLevel = hCnt_ff[7:0];

  // register port
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff      <= `PVT_CTRL_RST;
      hBlankReg_ff <= `PVT_HBLANK_TYP;
      vBlankReg_ff <= `PVT_VBLANK_TYP;
      color_ff     <= `PVT_COLOR_RST;
      regRdData    <= 32'h00000000;
    end else begin
      if (regWrEn) begin
        case (regAddr)
          `PVT_ADDR_CTRL: begin
            ctrl_ff <= regWrData[`PVT_CTRL_W-1:0];
          end
          `PVT_ADDR_HBLANK: begin
            hBlankReg_ff <= clampRange(regWrData[10:0],
                                       `PVT_HBLANK_MIN,
                                       `PVT_HBLANK_MAX);
          end
          `PVT_ADDR_VBLANK: begin
            vBlankReg_ff <= clampRange(regWrData[10:0],
                                       `PVT_VBLANK_MIN,
                                       `PVT_VBLANK_MAX);
          end
          `PVT_ADDR_COLOR: begin
            color_ff <= regWrData[23:0];
          end
          default: begin
          end
        endcase
      end
      if (regRdEn) begin
        case (regAddr)
          `PVT_ADDR_CTRL:   regRdData <= {27'h0000000, ctrl_ff};
          `PVT_ADDR_HBLANK: regRdData <= {21'h000000, hBlankReg_ff};
          `PVT_ADDR_VBLANK: regRdData <= {21'h000000, vBlankReg_ff};
          `PVT_ADDR_COLOR:  regRdData <= {8'h00, color_ff};
          `PVT_ADDR_STATUS: regRdData <= {25'h0000000, sigOn, state_ff};
          `PVT_ADDR_FRAMES: regRdData <= {16'h0000, frameCnt_ff};
          default:          regRdData <= 32'h00000000;
        endcase
      end else begin
        regRdData <= 32'h00000000;
      end
    end
  end

  // power and signal sequencer
  always @* begin
    nxt_state   = state_ff;
    nxt_waitCnt = waitCnt_ff;
    case (state_ff)
      S_OFF: begin
        if (runReq) begin
          nxt_state   = S_PWRUP;
          nxt_waitCnt = 32'h00000000;
        end
      end
      S_PWRUP: begin
        if (waitCnt_ff >= T1_CYCLES - 32'h00000001) begin
          nxt_state   = S_SIGON;
          nxt_waitCnt = 32'h00000000;
        end else begin
          nxt_waitCnt = waitCnt_ff + 32'h00000001;
        end
      end
      S_SIGON: begin
        if (!runReq) begin
          nxt_state   = S_STOP1;
          nxt_waitCnt = 32'h00000000;
        end else if (waitCnt_ff >= T2_CYCLES - 32'h00000001) begin
          nxt_state   = S_RUN;
          nxt_waitCnt = 32'h00000000;
        end else begin
          nxt_waitCnt = waitCnt_ff + 32'h00000001;
        end
      end
      S_RUN: begin
        if (!runReq) begin
          nxt_state   = S_STOP1;
          nxt_waitCnt = 32'h00000000;
        end
      end
      S_STOP1: begin
        if (waitCnt_ff >= T2_CYCLES - 32'h00000001) begin
          nxt_state   = S_STOP2;
          nxt_waitCnt = 32'h00000000;
        end else begin
          nxt_waitCnt = waitCnt_ff + 32'h00000001;
        end
      end
      S_STOP2: begin
        if (waitCnt_ff >= T3_CYCLES - 32'h00000001) begin
          nxt_state   = S_OFF;
          nxt_waitCnt = 32'h00000000;
        end else begin
          nxt_waitCnt = waitCnt_ff + 32'h00000001;
        end
      end
      default: begin
        nxt_state   = S_OFF;
        nxt_waitCnt = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff      <= S_OFF;
      waitCnt_ff    <= 32'h00000000;
      panelVccEn    <= 1'b0;
      backlightEn   <= 1'b0;
      panelResetN   <= 1'b0;
      panelStandbyN <= 1'b0;
      horizScanDir  <= 1'b0;
      vertScanDir   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      waitCnt_ff  <= nxt_waitCnt;
      panelVccEn  <= (nxt_state != S_OFF);
      // backlight only while video runs
      backlightEn <= (nxt_state == S_RUN) && ctrl_ff[`PVT_CTRL_BL];
      // control pins low while signals are off
      panelResetN   <= (nxt_state == S_SIGON) || (nxt_state == S_RUN) ||
                       (nxt_state == S_STOP1);
      panelStandbyN <= (nxt_state == S_SIGON) || (nxt_state == S_RUN) ||
                       (nxt_state == S_STOP1);
      if ((nxt_state == S_SIGON) || (nxt_state == S_RUN) ||
          (nxt_state == S_STOP1)) begin
        horizScanDir <= ctrl_ff[`PVT_CTRL_HDIR];
        vertScanDir  <= ctrl_ff[`PVT_CTRL_VDIR];
      end else begin
        horizScanDir <= 1'b0;
        vertScanDir  <= 1'b0;
      end
    end
  end

  // video timing, advanced once per rising pixel clock edge
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pixPrev_ff   <= 1'b0;
      hCnt_ff      <= 11'h000;
      vCnt_ff      <= 11'h000;
      hBlankAct_ff <= `PVT_HBLANK_TYP;
      vBlankAct_ff <= `PVT_VBLANK_TYP;
      frameCnt_ff  <= 16'h0000;
      pixelClk     <= 1'b0;
      pixelValid   <= 1'b0;
      pixRed       <= 8'h00;
      pixGreen     <= 8'h00;
      pixBlue      <= 8'h00;
      hsyncOut     <= 1'b0;
      vsyncOut     <= 1'b0;
    end else begin
      pixPrev_ff <= pixSync;
      hsyncOut   <= 1'b0;
      vsyncOut   <= 1'b0;
      pixelClk   <= sigOn & pixSync;
      if (!sigOn) begin
        hCnt_ff      <= 11'h000;
        vCnt_ff      <= 11'h000;
        hBlankAct_ff <= hBlankReg_ff;
        vBlankAct_ff <= vBlankReg_ff;
        pixelValid   <= 1'b0;
        pixRed       <= 8'h00;
        pixGreen     <= 8'h00;
        pixBlue      <= 8'h00;
      end else if (pixEdge) begin
        if (lineEnd) begin
          hCnt_ff <= 11'h000;
        end else begin
          hCnt_ff <= hCnt_ff + 11'h001;
        end
        if (frameEnd) begin
          // new blanking only at a frame boundary or while signals are off: whole lines only
          vCnt_ff      <= 11'h000;
          hBlankAct_ff <= hBlankReg_ff;
          vBlankAct_ff <= vBlankReg_ff;
          frameCnt_ff  <= frameCnt_ff + 16'h0001;
        end else if (lineEnd) begin
          vCnt_ff <= vCnt_ff + 11'h001;
        end
        pixelValid <= activeNow;
        if (!activeNow) begin
          pixRed   <= 8'h00;
          pixGreen <= 8'h00;
          pixBlue  <= 8'h00;
        end else if (ctrl_ff[`PVT_CTRL_RAMP]) begin
          pixRed   <= rampLevel;
          pixGreen <= rampLevel;
          pixBlue  <= rampLevel;
        end else begin
          pixRed   <= color_ff[23:16];
          pixGreen <= color_ff[15:8];
          pixBlue  <= color_ff[7:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== pvt_host_ctrl_chk.sv ====
// Purpose: assertions on the panel pins of the host controller
// Assumes: one clock domain, reset active high
// Notes:   pixel edges are found by sampling pixelClk
`default_nettype none
module pvt_host_ctrl_chk #(
  parameter int T1_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic panelVccEn,
  input wire logic backlightEn,
  input wire logic panelResetN,
  input wire logic panelStandbyN,
  input wire logic horizScanDir,
  input wire logic vertScanDir,
  input wire logic pixelClk,
  input wire logic pixelValid,
  input wire logic hsyncOut,
  input wire logic vsyncOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        clkQ_ff;
  logic        pixEdge;
  logic [16:0] runCnt_ff;
  logic [16:0] gapCnt_ff;
  logic [31:0] vccCnt_ff;
  assign pixEdge = pixelClk & ~clkQ_ff;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkQ_ff <= 1'b0;
      runCnt_ff <= 17'h0;
      gapCnt_ff <= 17'h0;
      vccCnt_ff <= 32'h0;
    end else begin
      clkQ_ff <= pixelClk;
      vccCnt_ff <= panelVccEn ? vccCnt_ff + 32'h1 : 32'h0;
      if (!panelResetN) begin
        runCnt_ff <= 17'h0;
        gapCnt_ff <= 17'h0;
      end else if (pixEdge) begin
        runCnt_ff <= pixelValid ? runCnt_ff + 17'h1 : 17'h0;
        gapCnt_ff <= pixelValid ? 17'h0 : gapCnt_ff + 17'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sync_low_a: assert property (!hsyncOut && !vsyncOut)
    else $error("sync output high");
  vcc_off_quiet_a: assert property (!panelVccEn |-> !(panelResetN |
    panelStandbyN | backlightEn | pixelClk | pixelValid | horizScanDir |
    vertScanDir)) else $error("pin high with supply off");
  powerup_gap_a: assert property ($rose(panelResetN) |->
    vccCnt_ff >= T1_CYCLES) else $error("signals on too early");
  vcc_after_sig_a: assert property ($fell(panelVccEn) |->
    !$past(panelResetN)) else $error("supply off before signals");
  bl_needs_video_a: assert property (backlightEn |->
    panelResetN && panelStandbyN) else $error("backlight while stopped");
  bl_off_first_a: assert property ($fell(panelStandbyN) |->
    !$past(backlightEn, 2)) else $error("backlight on at stop");
  valid_run_a: assert property (pixEdge && !pixelValid &&
    runCnt_ff != 17'h0 |-> runCnt_ff == 17'h500) else $error("bad run");
  hblank_gap_a: assert property (pixEdge && pixelValid &&
    gapCnt_ff != 17'h0 && gapCnt_ff < 17'h3c |->
    gapCnt_ff inside {[17'h6:17'ha]}) else $error("bad line gap");
endmodule
bind pvt_host_ctrl pvt_host_ctrl_chk #(.T1_CYCLES(T1_CYCLES)) u_chk (
  .core_clk, .sys_rst, .panelVccEn, .backlightEn, .panelResetN,
  .panelStandbyN, .horizScanDir, .vertScanDir, .pixelClk, .pixelValid,
  .hsyncOut, .vsyncOut
);
`default_nettype wire

// ==== pvt_panel_model.sv ====
// Purpose: behavioural panel capturing the video stream
// Assumes: data launched on the rising pixel clock edge
// Notes:   sampled on the falling edge, half a period later
`default_nettype none
module pvt_panel_model (
  input  wire logic       pixelClk,
  input  wire logic       pixelValid,
  input  wire logic [7:0] pixRed,
  input  wire logic [7:0] pixGreen,
  input  wire logic [7:0] pixBlue,
  input  wire logic       panelVccEn,
  input  wire logic       panelResetN,
  input  wire logic       panelStandbyN,
  input  wire logic       horizScanDir,
  input  wire logic       vertScanDir,
  output logic            leftToRight,
  output logic            topDown,
  output var logic [7:0]  lines,
  output var logic [15:0] runLen,
  output var logic [15:0] gapLen,
  output var logic [23:0] pix0,
  output var logic [23:0] pix255
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        active;
  logic [15:0] runCnt;
  logic [15:0] gapCnt;
  assign active = panelVccEn & panelResetN & panelStandbyN;
  // an undriven strap reads high
  assign leftToRight = horizScanDir !== 1'b0;
  assign topDown = vertScanDir !== 1'b0;
  initial begin
    lines = 8'h0;
    runCnt = 16'h0;
    gapCnt = 16'h0;
  end
  always @(negedge pixelClk or negedge active) begin
    if (!active) begin
      runCnt <= 16'h0;
      gapCnt <= 16'h0;
      lines <= 8'h0;
    end else if (pixelValid) begin
      if (runCnt == 16'h0) begin
        lines <= lines + 8'h1;
        gapLen <= gapCnt;
        pix0 <= {pixRed, pixGreen, pixBlue};
      end
      if (runCnt == 16'hff) pix255 <= {pixRed, pixGreen, pixBlue};
      runCnt <= runCnt + 16'h1;
      gapCnt <= 16'h0;
    end else begin
      if (runCnt != 16'h0) runLen <= runCnt;
      runCnt <= 16'h0;
      gapCnt <= gapCnt + 16'h1;
    end
  end
endmodule
`default_nettype wire

// ==== pvt_host_ctrl_tb.sv ====
// Purpose: self-checking bench for the video host controller
// Assumes: short power sequence counts, 80 ns pixel reference
// Notes:   a whole frame is too long to run, so lines are checked
`default_nettype none
`include "pvt_regs.vh"
module pvt_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        pixelClkRef = 1'b0;
  logic [31:0] regRdData, rdv;
  logic        panelVccEn, backlightEn, panelResetN, panelStandbyN;
  logic        horizScanDir, vertScanDir, pixelClk, pixelValid;
  logic        hsyncOut, vsyncOut, leftToRight, topDown;
  logic [7:0]  pixRed, pixGreen, pixBlue, lines;
  logic [15:0] runLen, gapLen, seed = 16'h0030;
  logic [23:0] pix0, pix255;
  logic [7:0]  regA [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  logic [31:0] regV [7] = '{32'hc, 32'h8, 32'h40, 32'h0, 32'h1, 32'h0, 32'h0};
  int          n_mismatch = 0;
  int          n_tests = 0;
  always #4 core_clk = ~core_clk;
  initial begin
    #3;
    forever #40 pixelClkRef = ~pixelClkRef;
  end
  pvt_host_ctrl #(.T1_CYCLES(32'h14), .T2_CYCLES(32'ha), .T3_CYCLES(32'ha))
  DUT (
    .core_clk, .sys_rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .pixelClkRef, .panelVccEn, .backlightEn, .panelResetN,
    .panelStandbyN, .horizScanDir, .vertScanDir, .pixelClk, .pixelValid,
    .pixRed, .pixGreen, .pixBlue, .hsyncOut, .vsyncOut
  );
  pvt_panel_model u_panel (
    .pixelClk, .pixelValid, .pixRed, .pixGreen, .pixBlue, .panelVccEn,
    .panelResetN, .panelStandbyN, .horizScanDir, .vertScanDir,
    .leftToRight, .topDown, .lines, .runLen, .gapLen, .pix0, .pix255
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] clampv(input logic [31:0] v, lo, hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  function automatic logic [23:0] pixel(input logic ramp,
                                        input logic [23:0] c,
                                        input logic [7:0] x);
    return ramp ? {x, x, x} : c;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic wait_status(input logic [31:0] exp);
    for (int i = 0; i < 200 && rdv !== exp; i++) rd(`PVT_ADDR_STATUS, rdv);
    check("status", rdv, exp);
  endtask
  task automatic run_case(input string name, input logic [31:0] hb,
                          input logic [4:0] ctrl, input logic [23:0] col);
    logic [31:0] hbx;
    hbx = clampv(hb, 32'h6, 32'ha);
    wr(`PVT_ADDR_HBLANK, hb);
    wr(`PVT_ADDR_COLOR, {8'h00, col});
    rd(`PVT_ADDR_HBLANK, rdv);
    check("hblank reg", rdv, hbx);
    wr(`PVT_ADDR_CTRL, {27'h0, ctrl});
    wait_status(32'h48);
    check("backlight", 32'(backlightEn), 32'(ctrl[1]));
    check("horiz dir", 32'(leftToRight), 32'(ctrl[2]));
    check("vert dir", 32'(topDown), 32'(ctrl[3]));
    for (int i = 0; i < 40000 && lines < 8'h2; i++) @(posedge core_clk);
    check("valid run", 32'(runLen), 32'h500);
    check("line gap", 32'(gapLen), hbx);
    check("line length", 32'(runLen + gapLen), 32'h500 + hbx);
    check("pixel 0", 32'(pix0), 32'(pixel(ctrl[4], col, 8'h00)));
    check("pixel 255", 32'(pix255), 32'(pixel(ctrl[4], col, 8'hff)));
    wr(`PVT_ADDR_CTRL, {27'h0, ctrl & 5'h1e});
    wait_status(32'h01);
    check("pins off", {panelVccEn, panelResetN, pixelValid}, 32'h0);
    $display("test %s done", name);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      rd(regA[k], rdv);
      check("reset value", rdv, regV[k]);
    end
    $display("test reset values done");
    wr(`PVT_ADDR_VBLANK, 32'h200);
    rd(`PVT_ADDR_VBLANK, rdv);
    check("vblank high", rdv, clampv(32'h200, 32'h3c, 32'h70));
    wr(`PVT_ADDR_VBLANK, 32'h10);
    rd(`PVT_ADDR_VBLANK, rdv);
    check("vblank low", rdv, clampv(32'h10, 32'h3c, 32'h70));
    $display("test vblank clamp done");
    seed = lfsr(seed);
    run_case("ramp", 32'h3, {1'b1, seed[1:0], 2'b11}, 24'h0);
    seed = lfsr(seed);
    run_case("solid", 32'hf, {1'b0, seed[1:0], seed[2], 1'b1},
             {seed[7:0], lfsr(seed)});
    stop_test();
  end
endmodule
`default_nettype wire
